// [hdl/bca_core.sv]
// What this block does
// - Self-discharge pin: high off, float charge/64, low charge/47 per day at 20-30 C.
// - Display pin: high absolute preset to full count, float absolute zero, low relative zero.
// - Available charge clears at init unless preset, and on valid charge after early empty.
// - Available charge counts up on charge but stops at learned capacity.
// - Available charge counts down on discharge and self-discharge, never below zero.
// - Tally takes both count kinds while charge nonzero, only discharge once empty.
// - Tally clears whenever available charge equals learned capacity, keeping only a count that leaves full in that cycle.
// - Tally saturates at all ones.
// - First valid charge after qualified early empty copies tally into learned capacity.
// - A qualified-discharge flag tracks whether the present discharge may update capacity.
// - Positive sense voltage counts charge proportionally after rate and temperature compensation.
// - With display enabled, charge above 4 mV lights the display.
// - Valid charge needs over 256 counts above charge deadband; counts until below it.
// - Discharge samples below discharge deadband accumulate; each full quantum decrements charge and bumps tally.
// - Discharge beyond -4 mV lights display; it goes dark above -4 mV.
// - Self-discharge runs continuously from time and temperature, temperature compensated only.
// - Charge and discharge counts are rate and temperature compensated first.
// - Charge is fast at two or more counts a second, trickle otherwise.
// - Fast charge factor applies until the rate is known.
// - Charge efficiency 0.80/0.95, 0.75/0.90, 0.65/0.80 by temperature band.
// - Two pins pick one of nine full-count presets, two pick the count scale.
// - At initialization learned capacity loads the full-count preset.
// - Discharge factor 1.00, or 1.05 beyond -150 mV, plus 0.05 per step below 10 C, up to four steps.
// - Discharge deadband is -45 over filter setting, charge deadband -1.25 times that.
//
// The implementer's own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module bca_core import bca_pkg::*; #(
    parameter int TICK_CYCLES = SECOND_CYCLES
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Programming pins, three-level codes
    input wire logic [1:0] preset_select_a,
    input wire logic [1:0] preset_select_b,
    input wire logic [1:0] scale_select_a,
    input wire logic [1:0] scale_select_b,
    input wire logic [1:0] self_discharge_rate_pin,
    input wire logic [1:0] display_mode_pin,
    input wire logic [1:0] led_enable_pin,
    // Measurement, same clock domain
    input wire logic sample_valid,
    input wire logic signed [23:0] corrected_sense_voltage,
    input wire logic [3:0] temp_step,
    // Voltage monitor, asynchronous latch level
    input wire logic early_empty_threshold,
    // Display
    output logic led_active
);

    typedef struct packed {
        logic [14:0] pin_s1;
        logic [14:0] pin_s2;
        logic init_done;
        logic [1:0] init_cnt;
        logic [15:0] available_charge_count;
        logic [15:0] learned_capacity;
        logic [15:0] discharge_tally;
        logic [7:0] filter_setting;
        logic [31:0] chg_acc;
        logic [31:0] dis_acc;
        logic [25:0] sd_acc;
        logic [23:0] sec_cnt;
        logic [8:0] run_cnt;
        logic chg_valid;
        logic [12:0] sd_total;
        logic [3:0] rate_cnt;
        logic fast;
        logic rate_known;
        logic charging;
        logic edv_seen;
        logic discharge_qualified_flag;
        logic led;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } bca_state_t;

    bca_state_t r;
    bca_state_t next_r;

    logic [1:0] p_a, p_b, p_s3, p_s4, p_sd, p_mode, p_led;
    logic edv_now, edv_prev;
    logic tick, chg_inc, dis_dec, sd_dec, valid_evt, learn, full;
    logic signed [23:0] dis_band, chg_band;
    logic [23:0] mag;
    logic [6:0] chg_factor, dis_factor;
    logic [31:0] quantum, prod;
    logic [25:0] sd_limit, sd_sum;
    logic [2:0] sd_shift;
    logic setup, access;
    logic [15:0] full_preset;

    assign {p_a, p_b, p_s3, p_s4, p_sd, p_mode, p_led, edv_now} = r.pin_s2;
    assign edv_prev = r.edv_seen;

    always_comb begin
        next_r = r;
        next_r.pin_s1 = {preset_select_a, preset_select_b, scale_select_a, scale_select_b,
                         self_discharge_rate_pin, display_mode_pin, led_enable_pin, early_empty_threshold};
        next_r.pin_s2 = r.pin_s1;
        full_preset = bca_full_preset(p_a, p_b);
        quantum = 32'(COUNT_QUANTUM) >> bca_scale(p_s3, p_s4);
        tick = (r.sec_cnt == 24'(TICK_CYCLES - 1));
        next_r.sec_cnt = tick ? 24'h0000_00 : r.sec_cnt + 24'h0000_01;
        // Deadbands; a zero filter write is refused so the divide is safe
        dis_band = -24'(DEADBAND_NUM_UV / int'(r.filter_setting));
        chg_band = 24'(CHARGE_DEADBAND_NUM_UV / int'(r.filter_setting));
        mag = corrected_sense_voltage[23] ? 24'(-corrected_sense_voltage) : corrected_sense_voltage;
        // Charge efficiency by band, fast until the rate is known
        if (temp_step < TEMP_THIRTY_C) begin
            chg_factor = (r.fast || !r.rate_known) ? 7'd95 : 7'd80;
        end else if (temp_step < TEMP_FORTY_C) begin
            chg_factor = (r.fast || !r.rate_known) ? 7'd90 : 7'd75;
        end else begin
            chg_factor = (r.fast || !r.rate_known) ? 7'd80 : 7'd65;
        end
        dis_factor = (int'(corrected_sense_voltage) < DISCHARGE_KNEE_UV) ? 7'd105 : 7'd100;
        if (temp_step < TEMP_TEN_C) begin
            dis_factor = dis_factor + 7'd5 * ((TEMP_TEN_C - temp_step > 4'h4) ? 7'd4 : 7'(TEMP_TEN_C - temp_step));
        end
        chg_inc = 1'b0;
        dis_dec = 1'b0;
        sd_dec = 1'b0;
        valid_evt = 1'b0;
        learn = 1'b0;
        prod = 32'h0000_0000;
        full = (r.available_charge_count == r.learned_capacity);
        // Charge and discharge accumulation
        if (r.init_done && sample_valid && corrected_sense_voltage > chg_band) begin
            prod = 32'(mag) * 32'(chg_factor);
            if (r.chg_acc + prod >= quantum) begin
                chg_inc = 1'b1;
                next_r.chg_acc = r.chg_acc + prod - quantum;
            end else begin
                next_r.chg_acc = r.chg_acc + prod;
            end
        end
        if (r.init_done && sample_valid && corrected_sense_voltage < dis_band) begin
            prod = 32'(mag) * 32'(dis_factor);
            if (r.dis_acc + prod >= quantum) begin
                dis_dec = 1'b1;
                next_r.dis_acc = r.dis_acc + prod - quantum;
            end else begin
                next_r.dis_acc = r.dis_acc + prod;
            end
        end
        // Valid charge qualification
        if (sample_valid && corrected_sense_voltage <= chg_band) begin
            next_r.run_cnt = 9'h000;
            next_r.chg_valid = 1'b0;
            next_r.charging = 1'b0;
        end else if (sample_valid) begin
            next_r.charging = 1'b1;
        end
        if (chg_inc && !r.chg_valid) begin
            if (r.run_cnt == VALID_CHARGE_COUNTS) begin
                valid_evt = 1'b1;
                next_r.chg_valid = 1'b1;
            end else begin
                next_r.run_cnt = r.run_cnt + 9'h001;
            end
        end
        // Rate classification once a second
        if (tick) begin
            next_r.fast = (r.rate_cnt >= FAST_RATE_COUNTS);
            next_r.rate_known = r.charging;
            next_r.rate_cnt = 4'h0;
        end else if (chg_inc && r.rate_cnt != 4'hF) begin
            next_r.rate_cnt = r.rate_cnt + 4'h1;
        end
        // Self-discharge, doubling per 10 C step
        sd_shift = (temp_step <= TEMP_ZERO_C) ? 3'h0 :
                   (temp_step - TEMP_ZERO_C > TEMP_MAX_SD_STEP) ? 3'h7 : 3'(temp_step - TEMP_ZERO_C);
        sd_limit = (p_sd == TRI_LOW) ? 26'(SD_DIV_LOW * SECONDS_PER_DAY) : 26'(SD_DIV_FLOAT * SECONDS_PER_DAY);
        sd_sum = r.sd_acc + (26'(r.available_charge_count) << sd_shift);
        if (r.init_done && tick && p_sd != TRI_HIGH) begin
            if (sd_sum >= sd_limit) begin
                sd_dec = (r.available_charge_count != 16'h0000);
                next_r.sd_acc = sd_sum - sd_limit;
            end else begin
                next_r.sd_acc = sd_sum;
            end
        end
        // Available charge
        if (chg_inc && r.available_charge_count < r.learned_capacity) begin
            next_r.available_charge_count = r.available_charge_count + 16'h0001;
        end
        if ((dis_dec || sd_dec) && r.available_charge_count != 16'h0000) begin
            next_r.available_charge_count = r.available_charge_count - 16'h0001;
        end
        // Tally: self-discharge only while charge remains
        if ((dis_dec || (sd_dec && r.available_charge_count != 16'h0000)) && r.discharge_tally != 16'hFFFF) begin
            next_r.discharge_tally = r.discharge_tally + 16'h0001;
        end
        if (full) begin
            // The count that leaves full is still tallied, or a learned capacity reads one short
            next_r.discharge_tally = {15'h0000, dis_dec || sd_dec};
            next_r.sd_total = 13'h0000;
            next_r.discharge_qualified_flag = 1'b1;
        end else if (sd_dec && r.sd_total != 13'h1FFF) begin
            next_r.sd_total = r.sd_total + 13'h0001;
        end
        if (r.sd_total > SELF_DISCHARGE_LIMIT) begin
            next_r.discharge_qualified_flag = 1'b0;
        end
        // Early empty latch and temperature check at that moment
        if (edv_now && !edv_prev && r.init_done) begin
            next_r.edv_seen = 1'b1;
            if (temp_step < TEMP_ZERO_C) begin
                next_r.discharge_qualified_flag = 1'b0;
            end
        end
        if (valid_evt) begin
            if (r.edv_seen) begin
                learn = r.discharge_qualified_flag;
                next_r.available_charge_count = 16'h0000;
                next_r.edv_seen = 1'b0;
                if (learn) begin
                    next_r.learned_capacity = r.discharge_tally;
                end
            end
            next_r.discharge_qualified_flag = 1'b0;
        end
        // Display drive
        if (p_led == TRI_HIGH) begin
            next_r.led = 1'b0;
        end else if (p_led == TRI_LOW) begin
            next_r.led = 1'b1;
        end else if (sample_valid) begin
            next_r.led = (int'(corrected_sense_voltage) > LED_LEVEL_UV) ||
                         (int'(corrected_sense_voltage) < -LED_LEVEL_UV);
        end
        // Initialization waits for the pin synchronisers to settle
        if (!r.init_done) begin
            next_r.init_cnt = r.init_cnt + 2'h1;
            if (r.init_cnt == INIT_WAIT) begin
                next_r.init_done = 1'b1;
                next_r.learned_capacity = full_preset;
                next_r.available_charge_count = (p_mode == TRI_HIGH) ? full_preset : 16'h0000;
                next_r.discharge_tally = 16'h0000;
                next_r.edv_seen = 1'b0;
                next_r.discharge_qualified_flag = 1'b0;
                next_r.sd_total = 13'h0000;
            end
        end
        // APB: zero wait states, data prepared in setup
        setup = psel && !penable;
        access = psel && penable && r.pready;
        next_r.pready = setup;
        next_r.pslverr = 1'b0;
        if (setup) begin
            case (paddr)
                ADDR_CHARGE: next_r.prdata = {16'h0000, r.available_charge_count};
                ADDR_CAPACITY: next_r.prdata = {16'h0000, r.learned_capacity};
                ADDR_TALLY: next_r.prdata = {16'h0000, r.discharge_tally};
                ADDR_STATUS: next_r.prdata = {23'h00_0000, p_mode, r.init_done, r.led, r.chg_valid,
                                              r.rate_known, r.fast, r.edv_seen, r.discharge_qualified_flag};
                ADDR_FILTER: next_r.prdata = {24'h00_0000, r.filter_setting};
                ADDR_CTRL: next_r.prdata = 32'h0000_0000;
                default: begin
                    next_r.prdata = 32'h0000_0000;
                    next_r.pslverr = 1'b1;
                end
            endcase
        end
        if (access && pwrite) begin
            if (paddr == ADDR_FILTER && pwdata[7:0] != 8'h00) begin
                next_r.filter_setting = pwdata[7:0];
            end
            if (paddr == ADDR_CTRL && pwdata[CTRL_REINIT_BIT]) begin
                next_r.init_done = 1'b0;
                next_r.init_cnt = 2'h0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
            r.filter_setting <= FILTER_RESET;
        end else begin
            r <= next_r;
        end
    end

    assign prdata = r.prdata;
    assign pready = r.pready;
    assign pslverr = r.pslverr;
    assign led_active = r.led;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence init_load_s;
        !r.init_done && r.init_cnt == INIT_WAIT;
    endsequence

    sequence learn_s;
        valid_evt && r.edv_seen && r.discharge_qualified_flag && r.init_done;
    endsequence

    nac_ceiling_a: assert property (r.init_done && chg_inc && full |=> r.available_charge_count <= $past(r.learned_capacity))
        else $error("available charge passed capacity");
    nac_floor_a: assert property (r.init_done && r.available_charge_count == 16'h0000 && !chg_inc |=> r.available_charge_count == 16'h0000)
        else $error("available charge wrapped below zero");
    tally_clear_a: assert property (r.init_done && full && !dis_dec && !sd_dec |=> r.discharge_tally == 16'h0000)
        else $error("tally not cleared at full");
    tally_sat_a: assert property (r.init_done && r.discharge_tally == 16'hFFFF && !full |=> r.discharge_tally == 16'hFFFF)
        else $error("tally wrapped");
    capacity_learn_a: assert property (learn_s |=> r.learned_capacity == $past(r.discharge_tally) && r.available_charge_count == 16'h0000)
        else $error("capacity not learned");
    init_preset_a: assert property (init_load_s ##1 1'b1 |-> r.learned_capacity == bca_full_preset(p_a, p_b) && r.init_done)
        else $error("capacity not preset at init");
    mode_load_a: assert property (init_load_s and (p_mode != TRI_HIGH) |=> r.available_charge_count == 16'h0000)
        else $error("available charge not cleared at init");
    sd_off_a: assert property (p_sd == TRI_HIGH |-> !sd_dec)
        else $error("self-discharge while disabled");
    led_on_a: assert property (p_led == TRI_LOW && $stable(p_led) |=> led_active)
        else $error("display not forced on");
    apb_answer_a: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("apb answer timing wrong");

endmodule : bca_core

`default_nettype wire

// [hdl/bca_pkg.sv]
package bca_pkg;

    // Three-level programming pin codes as delivered by the pad sensor
    localparam logic [1:0] TRI_LOW = 2'h0;
    localparam logic [1:0] TRI_FLOAT = 2'h1;
    localparam logic [1:0] TRI_HIGH = 2'h2;

    // Register byte offsets
    localparam logic [7:0] ADDR_CHARGE = 8'h00;
    localparam logic [7:0] ADDR_CAPACITY = 8'h04;
    localparam logic [7:0] ADDR_TALLY = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0C;
    localparam logic [7:0] ADDR_FILTER = 8'h10;
    localparam logic [7:0] ADDR_CTRL = 8'h14;
    localparam int CTRL_REINIT_BIT = 0;

    // Reset values
    localparam logic [7:0] FILTER_RESET = 8'h96;
    localparam logic [1:0] INIT_WAIT = 2'h3;

    // Time base
    localparam longint CLK_PERIOD_NS = 100;
    localparam longint SECOND_NS = 1_000_000_000;
    localparam int SECOND_CYCLES = int'(SECOND_NS / CLK_PERIOD_NS);
    localparam int SECONDS_PER_DAY = 86400;

    // Counting figures
    localparam logic [8:0] VALID_CHARGE_COUNTS = 9'h100;
    localparam logic [12:0] SELF_DISCHARGE_LIMIT = 13'h1000;
    localparam logic [3:0] FAST_RATE_COUNTS = 4'h2;
    localparam int LED_LEVEL_UV = 4000;
    localparam int DISCHARGE_KNEE_UV = -150000;
    localparam int DEADBAND_NUM_UV = 45000;
    localparam int CHARGE_DEADBAND_NUM_UV = 56250;
    localparam int COUNT_UV_SECONDS = 45000;
    localparam int SAMPLE_HZ = 16;
    localparam int PERCENT = 100;
    localparam int COUNT_QUANTUM = COUNT_UV_SECONDS * SAMPLE_HZ * PERCENT;
    localparam int SD_DIV_FLOAT = 256;
    localparam int SD_DIV_LOW = 188;

    // Temperature step codes (10 C steps, code 4 is 0..10 C)
    localparam logic [3:0] TEMP_ZERO_C = 4'h4;
    localparam logic [3:0] TEMP_TEN_C = 4'h5;
    localparam logic [3:0] TEMP_THIRTY_C = 4'h7;
    localparam logic [3:0] TEMP_FORTY_C = 4'h8;
    localparam logic [3:0] TEMP_MAX_SD_STEP = 4'h7;

    // H=0, Z=1, L=2 position in the preset tables
    function automatic logic [1:0] bca_tri_idx(input logic [1:0] pin);
        bca_tri_idx = (pin == TRI_HIGH) ? 2'h0 : (pin == TRI_FLOAT) ? 2'h1 : 2'h2;
    endfunction : bca_tri_idx

    function automatic logic [15:0] bca_full_preset(input logic [1:0] a, input logic [1:0] b);
        logic [15:0] tbl [9];
        tbl = '{16'hC000, 16'hB000, 16'hA000, 16'h9000, 16'h8400, 16'h7800, 16'h6C00, 16'h6400, 16'h5800};
        bca_full_preset = tbl[4'(bca_tri_idx(a)) * 4'h3 + 4'(bca_tri_idx(b))];
    endfunction : bca_full_preset

    // Scale index 0 (1/80) .. 5 (1/2560)
    function automatic logic [2:0] bca_scale(input logic [1:0] s3, input logic [1:0] s4);
        bca_scale = ((s4 == TRI_LOW) ? 3'h0 : 3'h3) + 3'(bca_tri_idx(s3));
    endfunction : bca_scale

endpackage : bca_pkg

// [sim/bca_sense_model.sv]
`timescale 1ns/1ps
`default_nettype none

module bca_sense_model (
    // Clock
    input wire logic pclk,
    // Sense resistor and cell divider
    output logic sample_valid,
    output logic signed [23:0] corrected_sense_voltage,
    output logic early_empty_threshold
);
    initial begin
        sample_valid = 1'b0;
        corrected_sense_voltage = 24'h00_0000;
        early_empty_threshold = 1'b0;
    end

    // One sample every four cycles; the value is scrambled between samples
    // so a design that reads it late sees garbage, not a stale copy
    task automatic burst(input int n, input logic signed [23:0] v);
        for (int i = 0; i < n; i++) begin
            @(posedge pclk);
            sample_valid <= 1'b1;
            corrected_sense_voltage <= v;
            @(posedge pclk);
            sample_valid <= 1'b0;
            corrected_sense_voltage <= ~v;
            repeat (2) @(posedge pclk);
        end
    endtask : burst

    // Cell dips under the early warning level, then recovers
    task automatic cell_low();
        @(posedge pclk);
        early_empty_threshold <= 1'b1;
        repeat (6) @(posedge pclk);
        early_empty_threshold <= 1'b0;
    endtask : cell_low
endmodule : bca_sense_model

`default_nettype wire

// [sim/battery_charge_accounting_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none

module battery_charge_accounting_tb_top import bca_pkg::*;;
    // Short tick keeps the rate decision fast in simulation
    localparam int TICK = 100;
    localparam int LIMIT = 20000;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, led_active;
    logic sample_valid, early_empty_threshold;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic signed [23:0] corrected_sense_voltage;
    logic [1:0] pa, pb, sa, sb, sdr, dmode, leden;
    logic [3:0] temp_step;
    int n_mismatch = 0;
    int samples_checked = 0;
    int cycles = 0;
    logic [1:0] tri_code [3] = '{TRI_HIGH, TRI_FLOAT, TRI_LOW};
    logic [15:0] preset_exp [9] = '{16'hC000, 16'hB000, 16'hA000, 16'h9000, 16'h8400,
        16'h7800, 16'h6C00, 16'h6400, 16'h5800};

    bca_core #(.TICK_CYCLES(TICK)) i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .preset_select_a(pa), .preset_select_b(pb), .scale_select_a(sa), .scale_select_b(sb),
        .self_discharge_rate_pin(sdr), .display_mode_pin(dmode), .led_enable_pin(leden),
        .sample_valid(sample_valid), .corrected_sense_voltage(corrected_sense_voltage),
        .temp_step(temp_step), .early_empty_threshold(early_empty_threshold),
        .led_active(led_active));

    bca_sense_model i_model (.pclk(pclk), .sample_valid(sample_valid),
        .corrected_sense_voltage(corrected_sense_voltage), .early_empty_threshold(early_empty_threshold));

    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            n_mismatch++;
            conclude();
        end
    end

    task automatic conclude();
        $display("Comparisons %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : conclude

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            $display("ERROR %s expected %h seen %h", what, exp, got);
            n_mismatch++;
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int k;
        k = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        chk("pready", 32'h0000_0001, {31'h0, pready});
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(what, exp, rd);
    endtask : rdchk

    // Pins pass a two-flop synchroniser before the reload sees them
    task automatic reinit();
        repeat (4) @(posedge pclk);
        apb(1'b1, ADDR_CTRL, 32'h0000_0001);
        repeat (8) @(posedge pclk);
    endtask : reinit

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        pa = TRI_FLOAT;
        pb = TRI_FLOAT;
        sa = TRI_LOW;
        sb = TRI_FLOAT;
        sdr = TRI_HIGH;
        dmode = TRI_HIGH;
        leden = TRI_FLOAT;
        temp_step = 4'h6;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        repeat (8) @(posedge pclk);
        rdchk("charge", ADDR_CHARGE, 32'h0000_8400);
        rdchk("filter", ADDR_FILTER, 32'h0000_0096);
        apb(1'b1, ADDR_FILTER, 32'h0000_0000);
        rdchk("filter", ADDR_FILTER, 32'h0000_0096);
        apb(1'b1, ADDR_CHARGE, 32'h0000_0001);
        rdchk("charge", ADDR_CHARGE, 32'h0000_8400);
        apb(1'b0, 8'h18, 32'h0000_0000);
        chk("unmapped error", 32'h0000_0001, {31'h0, err});
        for (int i = 0; i < 9; i++) begin
            pa <= tri_code[i / 3];
            pb <= tri_code[i % 3];
            dmode <= tri_code[i % 3];
            reinit();
            rdchk("capacity", ADDR_CAPACITY, {16'h0000, preset_exp[i]});
            rdchk("charge", ADDR_CHARGE, (i % 3 == 0) ? {16'h0000, preset_exp[i]} : 32'h0000_0000);
            rdchk("tally", ADDR_TALLY, 32'h0000_0000);
        end
        pa <= TRI_FLOAT;
        pb <= TRI_FLOAT;
        dmode <= TRI_HIGH;
        reinit();
        apb(1'b0, ADDR_STATUS, 32'h0000_0000);
        chk("qualified", 32'h0000_0001, {31'h0, rd[0]});
        i_model.burst(20, 24'h00_5DC0);
        rdchk("charge", ADDR_CHARGE, 32'h0000_8400);
        chk("led", 32'h0000_0001, {31'h0, led_active});
        i_model.burst(5, -24'sh00_00FA);
        rdchk("tally", ADDR_TALLY, 32'h0000_0000);
        // One count per sample: 22.5 mV at unit factor equals the quantum
        i_model.burst(300, -24'sh00_57E4);
        chk("led", 32'h0000_0001, {31'h0, led_active});
        rdchk("charge", ADDR_CHARGE, 32'h0000_82D4);
        rdchk("tally", ADDR_TALLY, 32'h0000_012C);
        i_model.burst(1, -24'sh00_03E8);
        chk("led", 32'h0000_0000, {31'h0, led_active});
        i_model.cell_low();
        apb(1'b0, ADDR_STATUS, 32'h0000_0000);
        chk("early empty", 32'h0000_0001, {31'h0, rd[1]});
        i_model.burst(700, 24'h00_5DC0);
        rdchk("capacity", ADDR_CAPACITY, 32'h0000_012C);
        rdchk("charge", ADDR_CHARGE, 32'h0000_012C);
        rdchk("tally", ADDR_TALLY, 32'h0000_0000);
        dmode <= TRI_FLOAT;
        leden <= TRI_HIGH;
        reinit();
        i_model.burst(3, -24'sh00_57E4);
        rdchk("charge", ADDR_CHARGE, 32'h0000_0000);
        rdchk("tally", ADDR_TALLY, 32'h0000_0003);
        chk("led", 32'h0000_0000, {31'h0, led_active});
        leden <= TRI_LOW;
        repeat (4) @(posedge pclk);
        chk("led", 32'h0000_0001, {31'h0, led_active});
        // Hot cell, low pin: one self-discharge count per four ticks, so 500 cycles give exactly one
        sdr <= TRI_LOW;
        dmode <= TRI_HIGH;
        temp_step <= 4'hB;
        reinit();
        repeat (500) @(posedge pclk);
        rdchk("charge", ADDR_CHARGE, 32'h0000_83FF);
        rdchk("tally", ADDR_TALLY, 32'h0000_0001);
        conclude();
    end
endmodule : battery_charge_accounting_tb_top

`default_nettype wire
